/* inc/load_limit_status_map.vh */
// Purpose: constants for the load limit and status command block
// Assumes: commands arrive already parsed into a code and a numeric argument
// Notes:   limit index 0..7 is taken from the low three bits of a limit command
`ifndef LOAD_LIMIT_STATUS_MAP_VH
`define LOAD_LIMIT_STATUS_MAP_VH

`define VAL_W            24
`define CODE_W           6

// limit slots
`define LIM_N            8
`define LIM_IDX_W        3
`define LIM_LOWER_CURR   3'h0
`define LIM_UPPER_CURR   3'h1
`define LIM_LOWER_PWR    3'h2
`define LIM_UPPER_PWR    3'h3
`define LIM_LOWER_VOLT   3'h4
`define LIM_UPPER_VOLT   3'h5
`define LIM_SHORT_LOWER  3'h6
`define LIM_SHORT_UPPER  3'h7
`define LIM_RESET        24'h000000

// command codes
`define CMD_LIM_SET      3'h0
`define CMD_LIM_QRY      3'h1
`define CMD_GROUP_SET    2'h0
`define CMD_LOAD         6'h10
`define CMD_MODE         6'h11
`define CMD_SHORT        6'h12
`define CMD_PRESET       6'h13
`define CMD_SENSE        6'h14
`define CMD_LEVEL        6'h15
`define CMD_DYNAMIC      6'h16
`define CMD_CLR          6'h17
`define CMD_RANGE        6'h18
`define CMD_METER_SIGN_SELECT        6'h19
`define CMD_TFUNC        6'h1a
`define CMD_START        6'h1b
`define CMD_STOP         6'h1c
`define QRY_LOAD         6'h20
`define QRY_MODE         6'h21
`define QRY_SHORT        6'h22
`define QRY_PRESET       6'h23
`define QRY_SENSE        6'h24
`define QRY_LEVEL        6'h25
`define QRY_DYNAMIC      6'h26
`define QRY_ERR          6'h27
`define QRY_NG           6'h28
`define QRY_PROTECTION_STATUS         6'h29
`define QRY_TFUNC        6'h2a

// operating modes
`define MODE_CC          2'h0
`define MODE_CR          2'h1
`define MODE_CV          2'h2
`define MODE_CP          2'h3

// sense settings as written
`define SENSE_OFF        2'h0
`define SENSE_ON         2'h1
`define SENSE_AUTO       2'h2

// test functions
`define TF_NORMAL        3'h0
`define TF_OVER_CURR     3'h1
`define TF_OVER_VOLT     3'h2
`define TF_OVER_PWR      3'h3
`define TF_SHORT         3'h4

// status registers
`define ERR_W            6
`define ERR_CH1_LSB      0
`define ERR_CH1_MSB      3
`define ERR_OPERATION    4
`define ERR_SYNTAX       5
`define PROTECTION_STATUS_W           4
`define PROTECTION_STATUS_OVER_PWR    0
`define PROTECTION_STATUS_OVER_TEMP   1
`define PROTECTION_STATUS_OVER_VOLT   2
`define PROTECTION_STATUS_OVER_CURR   3

`endif

/* design/band_check.v */
// Purpose: window comparison of one measured value against a limit pair
// Assumes: unsigned values, lower not above upper
// Notes:   combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_status_map.vh"

module band_check (
    input  wire [`VAL_W-1:0] value_i,
    input  wire [`VAL_W-1:0] lower_i,
    input  wire [`VAL_W-1:0] upper_i,
    output wire              outside_o
);
    // equal to a limit still counts as inside the band
    assign outside_o = (value_i < lower_i) || (value_i > upper_i);
endmodule // band_check

`default_nettype wire

/* design/load_limit_status_commands.v */
// Purpose: command handler for limits, operating state, status registers and tests
// Assumes: a front end has parsed each text command into code and argument
// Notes:   one command per cycle may be offered; each query answers one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_status_map.vh"

module load_limit_status_commands (
    input  wire                 mclk_i,
    input  wire                 nrst_i,
    input  wire                 cmd_valid_i,
    input  wire [`CODE_W-1:0]   cmd_code_i,
    input  wire [`VAL_W-1:0]    cmd_arg_i,
    input  wire [`VAL_W-1:0]    meas_current_i,
    input  wire [`VAL_W-1:0]    meas_power_i,
    input  wire [`VAL_W-1:0]    meas_voltage_i,
    input  wire [3:0]           ch1_err_i,
    input  wire                 op_err_i,
    input  wire                 over_power_trip_i,
    input  wire                 over_temp_trip_i,
    input  wire                 over_voltage_trip_i,
    input  wire                 over_current_trip_i,
    output reg                  resp_valid_o,
    output reg  [`VAL_W-1:0]    resp_data_o,
    output reg                  out_of_band_flag_o,
    output reg                  load_on_o,
    output reg  [1:0]           mode_o,
    output reg                  short_test_active_o,
    output reg                  preset_on_o,
    output reg                  sense_forced_o,
    output reg                  sense_auto_o,
    output reg                  level_high_o,
    output reg                  static_op_o,
    output reg                  second_range_o,
    output reg                  meter_sign_neg_o,
    output reg  [2:0]           test_function_select_o,
    output reg                  test_running_o,
    output reg  [`ERR_W-1:0]    error_status_o,
    output reg  [`PROTECTION_STATUS_W-1:0]   protection_status_o
);

    // limit store: lower/upper pairs at even/odd slots
    reg  [`VAL_W-1:0] lim [0:`LIM_N-1];
    integer           i;

    function is_limit_cmd;
        input [`CODE_W-1:0] c;
        input [2:0]         grp;
        begin
            is_limit_cmd = (c[`CODE_W-1:`LIM_IDX_W] == grp);
        end
    endfunction

    // one command per cycle; nothing here stalls the front end
    wire do_cmd = cmd_valid_i;
    wire lim_set = do_cmd && is_limit_cmd(cmd_code_i, `CMD_LIM_SET);
    wire lim_qry = do_cmd && is_limit_cmd(cmd_code_i, `CMD_LIM_QRY);
    wire [`LIM_IDX_W-1:0] lim_idx = cmd_code_i[`LIM_IDX_W-1:0];

    // window comparisons; the host keeps lower <= upper, otherwise the band is empty
    wire curr_out;
    wire pwr_out;
    wire volt_out;
    wire short_out;

    band_check u_curr (
        .value_i   (meas_current_i),
        .lower_i   (lim[`LIM_LOWER_CURR]),
        .upper_i   (lim[`LIM_UPPER_CURR]),
        .outside_o (curr_out)
    );
    band_check u_pwr (
        .value_i   (meas_power_i),
        .lower_i   (lim[`LIM_LOWER_PWR]),
        .upper_i   (lim[`LIM_UPPER_PWR]),
        .outside_o (pwr_out)
    );
    band_check u_volt (
        .value_i   (meas_voltage_i),
        .lower_i   (lim[`LIM_LOWER_VOLT]),
        .upper_i   (lim[`LIM_UPPER_VOLT]),
        .outside_o (volt_out)
    );
    // the short band watches the same voltage input as the normal band
    band_check u_short (
        .value_i   (meas_voltage_i),
        .lower_i   (lim[`LIM_SHORT_LOWER]),
        .upper_i   (lim[`LIM_SHORT_UPPER]),
        .outside_o (short_out)
    );

    // short-test band replaces the normal voltage band while the short test runs
    wire next_ng = short_test_active_o ? (curr_out || pwr_out || short_out)
                 : (curr_out || pwr_out || volt_out);

    // command decode
    wire is_clr   = do_cmd && (cmd_code_i == `CMD_CLR);
    wire is_start = do_cmd && (cmd_code_i == `CMD_START);
    wire is_stop  = do_cmd && (cmd_code_i == `CMD_STOP);
    wire bad_sense = (cmd_arg_i[1:0] > `SENSE_AUTO);
    wire bad_tfunc = (cmd_arg_i[2:0] > `TF_SHORT);

    reg known;
    reg bad_arg;
    always @* begin
        known   = 1'b1;
        bad_arg = 1'b0;
        if (lim_set || lim_qry) begin
            known = 1'b1;
        end else begin
            case (cmd_code_i)
                `CMD_LOAD,
                `CMD_MODE,
                `CMD_SHORT,
                `CMD_PRESET,
                `CMD_LEVEL,
                `CMD_DYNAMIC,
                `CMD_CLR,
                `CMD_RANGE,
                `CMD_METER_SIGN_SELECT,
                `CMD_START,
                `CMD_STOP,
                `QRY_LOAD,
                `QRY_MODE,
                `QRY_SHORT,
                `QRY_PRESET,
                `QRY_SENSE,
                `QRY_LEVEL,
                `QRY_DYNAMIC,
                `QRY_ERR,
                `QRY_NG,
                `QRY_PROTECTION_STATUS,
                `QRY_TFUNC: begin
                    known = 1'b1;
                end
                // a refused argument leaves the state alone and only sets the syntax bit
                `CMD_SENSE: bad_arg = bad_sense;
                `CMD_TFUNC: bad_arg = bad_tfunc;
                default: known = 1'b0;
            endcase
        end
    end

    wire syntax_err = do_cmd && (!known || bad_arg);
    // starting a test with the load input switched off is refused as an operation error
    wire start_refused = is_start && !load_on_o;

    // sticky status: a new event in the clearing cycle still lands
    wire [`ERR_W-1:0] err_events;
    assign err_events[`ERR_CH1_MSB:`ERR_CH1_LSB] = ch1_err_i;
    assign err_events[`ERR_OPERATION] = op_err_i || start_refused;
    assign err_events[`ERR_SYNTAX]    = syntax_err;
    wire [`PROTECTION_STATUS_W-1:0] protection_status_events;
    assign protection_status_events[`PROTECTION_STATUS_OVER_PWR]  = over_power_trip_i;
    assign protection_status_events[`PROTECTION_STATUS_OVER_TEMP] = over_temp_trip_i;
    assign protection_status_events[`PROTECTION_STATUS_OVER_VOLT] = over_voltage_trip_i;
    assign protection_status_events[`PROTECTION_STATUS_OVER_CURR] = over_current_trip_i;

    wire [`ERR_W-1:0]  next_err  = (is_clr ? {`ERR_W{1'b0}} : error_status_o) | err_events;
    wire [`PROTECTION_STATUS_W-1:0] next_protection_status = (is_clr ? {`PROTECTION_STATUS_W{1'b0}} : protection_status_o)
                                   | protection_status_events;

    // query answers
    reg [`VAL_W-1:0] next_resp;
    reg              next_resp_valid;
    always @* begin
        next_resp       = {`VAL_W{1'b0}};
        next_resp_valid = do_cmd && known;
        if (lim_qry) begin
            // limit queries answer with the stored word in full width
            next_resp = lim[lim_idx];
        end else begin
            case (cmd_code_i)
                `QRY_LOAD:    next_resp[0]   = load_on_o;
                `QRY_MODE:    next_resp[1:0] = mode_o;
                `QRY_SHORT:   next_resp[0]   = !short_test_active_o;
                `QRY_PRESET:  next_resp[0]   = preset_on_o;
                `QRY_SENSE:   next_resp[0]   = sense_forced_o;
                `QRY_LEVEL:   next_resp[0]   = level_high_o;
                `QRY_DYNAMIC: next_resp[0]   = static_op_o;
                `QRY_ERR:     next_resp[`ERR_W-1:0]  = error_status_o;
                `QRY_NG:      next_resp[0]   = out_of_band_flag_o;
                `QRY_PROTECTION_STATUS:    next_resp[`PROTECTION_STATUS_W-1:0] = protection_status_o;
                `QRY_TFUNC:   next_resp[2:0] = test_function_select_o;
                default:      next_resp_valid = 1'b0;
            endcase
        end
    end

    // limit store writes
    // limits start at zero, so no-good stands until each pair is written
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (i = 0; i < `LIM_N; i = i + 1) begin
                lim[i] <= `LIM_RESET;
            end
        end else if (lim_set) begin
            lim[lim_idx] <= cmd_arg_i;
        end
    end

    // operating state and test control
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            load_on_o              <= 1'b0;
            mode_o                 <= `MODE_CC;
            short_test_active_o    <= 1'b0;
            preset_on_o            <= 1'b0;
            sense_forced_o         <= 1'b0;
            sense_auto_o           <= 1'b0;
            level_high_o           <= 1'b0;
            static_op_o            <= 1'b1;
            second_range_o         <= 1'b0;
            meter_sign_neg_o       <= 1'b0;
            test_function_select_o <= `TF_NORMAL;
            test_running_o         <= 1'b0;
        end else begin
            if (do_cmd) begin
                case (cmd_code_i)
                    `CMD_LOAD:    load_on_o    <= cmd_arg_i[0];
                    `CMD_MODE:    mode_o       <= cmd_arg_i[1:0];
                    // the short command runs the short band outside the test sequence
                    `CMD_SHORT:   short_test_active_o <= cmd_arg_i[0];
                    `CMD_PRESET:  preset_on_o  <= cmd_arg_i[0];
                    `CMD_SENSE: begin
                        if (!bad_sense) begin
                            sense_forced_o <= (cmd_arg_i[1:0] == `SENSE_ON);
                            sense_auto_o   <= (cmd_arg_i[1:0] == `SENSE_AUTO);
                        end
                    end
                    `CMD_LEVEL:   level_high_o <= cmd_arg_i[0];
                    // argument 1 asks for dynamic operation, so static is its inverse
                    `CMD_DYNAMIC: static_op_o  <= !cmd_arg_i[0];
                    `CMD_RANGE:   second_range_o   <= cmd_arg_i[0];
                    `CMD_METER_SIGN_SELECT:   meter_sign_neg_o <= cmd_arg_i[0];
                    `CMD_TFUNC: begin
                        // changing the function mid-test would re-aim a running test
                        if (!bad_tfunc && !test_running_o) begin
                            test_function_select_o <= cmd_arg_i[2:0];
                        end
                    end
                    `CMD_START: begin
                        if (!start_refused) begin
                            test_running_o <= 1'b1;
                            if (test_function_select_o == `TF_SHORT) begin
                                short_test_active_o <= 1'b1;
                            end
                        end
                    end
                    `CMD_STOP: begin
                        // stop also ends a short test started by the short command
                        test_running_o      <= 1'b0;
                        short_test_active_o <= 1'b0;
                    end
                    default: test_running_o <= test_running_o;
                endcase
            end
        end
    end

    // flags, status and answers
    // answer data is rewritten every cycle, so nothing stale outlives its strobe
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_of_band_flag_o  <= 1'b0;
            error_status_o      <= {`ERR_W{1'b0}};
            protection_status_o <= {`PROTECTION_STATUS_W{1'b0}};
            resp_valid_o        <= 1'b0;
            resp_data_o         <= {`VAL_W{1'b0}};
        end else begin
            out_of_band_flag_o  <= next_ng;
            error_status_o      <= next_err;
            protection_status_o <= next_protection_status;
            resp_valid_o        <= next_resp_valid;
            resp_data_o         <= next_resp;
        end
    end

endmodule // load_limit_status_commands

`default_nettype wire

/* sim/host_cmd_model.sv */
// Purpose: host side of the command port, one parsed command per send call
// Assumes: commands change on the falling edge and are taken on the next rising edge
// Notes:   idle code and argument show the inverse of the last command, never a stale copy
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_status_map.vh"

module host_cmd_model (
    input  wire logic              mclk_i,
    output logic                   cmd_valid_o,
    output logic [`CODE_W-1:0]     cmd_code_o,
    output logic [`VAL_W-1:0]      cmd_arg_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 6'h00;
        cmd_arg_o = 24'h000000;
    end

    task automatic send(input logic [5:0] c, input logic [23:0] a);
        @(negedge mclk_i);
        cmd_valid_o = 1'b1;
        cmd_code_o = c;
        cmd_arg_o = a;
        @(negedge mclk_i);
        cmd_valid_o = 1'b0;
        cmd_code_o = ~c;
        cmd_arg_o = ~a;
    endtask

    // lower is zeroed first so it never stands above the upper limit
    task automatic set_band(input logic [2:0] lo_slot, input logic [23:0] lo, input logic [23:0] hi);
        send({3'h0, lo_slot}, 24'h000000);
        send({3'h0, lo_slot | 3'h1}, hi);
        send({3'h0, lo_slot}, lo);
    endtask
endmodule // host_cmd_model
`default_nettype wire

/* sim/load_limit_status_commands_checker.sv */
// Purpose: port-level assertions for the limit and status command block
// Assumes: one clock, asynchronous active-low reset
// Notes:   no-good band checks need the limits, so those are left to the bench
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_status_map.vh"

module load_limit_status_commands_checker (
    input  wire logic                mclk_i,
    input  wire logic                nrst_i,
    input  wire logic                cmd_valid_i,
    input  wire logic [`CODE_W-1:0]  cmd_code_i,
    input  wire logic [3:0]          ch1_err_i,
    input  wire logic                op_err_i,
    input  wire logic                over_power_trip_i,
    input  wire logic                over_temp_trip_i,
    input  wire logic                over_voltage_trip_i,
    input  wire logic                over_current_trip_i,
    input  wire logic                resp_valid_o,
    input  wire logic [`VAL_W-1:0]   resp_data_o,
    input  wire logic                load_on_o,
    input  wire logic [1:0]          mode_o,
    input  wire logic                short_test_active_o,
    input  wire logic                sense_forced_o,
    input  wire logic                static_op_o,
    input  wire logic                test_running_o,
    input  wire logic [`ERR_W-1:0]   error_status_o,
    input  wire logic [`PROTECTION_STATUS_W-1:0]  protection_status_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    wire clr_cmd = cmd_valid_i && cmd_code_i == `CMD_CLR;
    wire no_event = ch1_err_i == 4'h0 && !op_err_i && !over_power_trip_i && !over_temp_trip_i
                    && !over_voltage_trip_i && !over_current_trip_i;

    chk_load_answer: assert property (cmd_valid_i && cmd_code_i == `QRY_LOAD
        |=> resp_valid_o && resp_data_o == {23'h0, load_on_o}) else $error("load answer wrong");
    chk_mode_answer: assert property (cmd_valid_i && cmd_code_i == `QRY_MODE
        |=> resp_valid_o && resp_data_o == {22'h0, mode_o}) else $error("mode answer wrong");
    chk_short_answer: assert property (cmd_valid_i && cmd_code_i == `QRY_SHORT
        |=> resp_data_o[0] == !short_test_active_o) else $error("short answer wrong");
    chk_sense_answer: assert property (cmd_valid_i && cmd_code_i == `QRY_SENSE
        |=> resp_data_o[0] == sense_forced_o) else $error("sense answer wrong");
    chk_static_answer: assert property (cmd_valid_i && cmd_code_i == `QRY_DYNAMIC
        |=> resp_data_o[0] == static_op_o) else $error("static answer wrong");
    chk_clear_zeroes: assert property (clr_cmd && no_event
        |=> error_status_o == 6'h00 && protection_status_o == 4'h0) else $error("clear failed");
    chk_status_sticky: assert property (!clr_cmd
        |=> (error_status_o & $past(error_status_o)) == $past(error_status_o))
        else $error("error bit dropped");
    chk_trip_bit: assert property (over_current_trip_i && !clr_cmd
        |=> protection_status_o[3] [*2]) else $error("current trip bit missing");
    chk_syntax_bit: assert property (cmd_valid_i && cmd_code_i == 6'h3f
        |=> error_status_o[5] && !resp_valid_o) else $error("syntax bit missing");
    chk_start_off: assert property (cmd_valid_i && cmd_code_i == `CMD_START && !load_on_o
        |=> error_status_o[4] && !test_running_o) else $error("start while off accepted");

    cov_clear: cover property (clr_cmd ##1 error_status_o == 6'h00);
    cov_short: cover property ($rose(short_test_active_o));
    cov_trip: cover property (protection_status_o == 4'hf);
endmodule // load_limit_status_commands_checker

bind load_limit_status_commands load_limit_status_commands_checker load_limit_status_commands_checker_i (.*);
`default_nettype wire

/* sim/load_limit_status_commands_tb.sv */
// Purpose: directed command sequences with expected answers
// Assumes: inputs change on the falling edge
// Notes:   answers are read on the falling edge right after the command edge, as the port promises
`timescale 1ns/100ps
`default_nettype none
`include "load_limit_status_map.vh"

module load_limit_status_commands_tb;
    logic mclk_i, nrst_i, cmd_valid_i, op_err_i, resp_valid_o, out_of_band_flag_o, load_on_o;
    logic over_power_trip_i, over_temp_trip_i, over_voltage_trip_i, over_current_trip_i;
    logic short_test_active_o, preset_on_o, sense_forced_o, sense_auto_o, level_high_o;
    logic static_op_o, second_range_o, meter_sign_neg_o, test_running_o;
    logic [5:0]  cmd_code_i, error_status_o;
    logic [23:0] cmd_arg_i, meas_current_i, meas_power_i, meas_voltage_i, resp_data_o;
    logic [3:0]  ch1_err_i, protection_status_o;
    logic [2:0]  test_function_select_o;
    logic [1:0]  mode_o;
    int          errors, num_checks;
    logic [5:0]  sc [4] = '{`CMD_LOAD, `CMD_PRESET, `CMD_LEVEL, `CMD_DYNAMIC};
    logic [5:0]  qc [4] = '{`QRY_LOAD, `QRY_PRESET, `QRY_LEVEL, `QRY_DYNAMIC};

    load_limit_status_commands load_limit_status_commands_i (.*);
    host_cmd_model host_cmd_model_i (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i),
        .cmd_code_o(cmd_code_i), .cmd_arg_o(cmd_arg_i));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic query(input logic [5:0] c, input logic [23:0] exp);
        host_cmd_model_i.send(c, 24'h0);
        check(resp_valid_o, 1'b1);
        check(resp_data_o, exp);
    endtask

    task automatic meas(input logic [23:0] i, input logic [23:0] p, input logic [23:0] v, input logic e);
        @(negedge mclk_i);
        {meas_current_i, meas_power_i, meas_voltage_i} = {i, p, v};
        @(negedge mclk_i);
        check(out_of_band_flag_o, e);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // whole run is under a thousand cycles, so this margin only catches a hang
    initial begin
        #200000;
        errors++;
        final_report();
    end

    initial begin
        nrst_i = 1'b0;
        {meas_current_i, meas_power_i, meas_voltage_i, ch1_err_i, op_err_i} = '0;
        {over_power_trip_i, over_temp_trip_i, over_voltage_trip_i, over_current_trip_i} = 4'h0;
        repeat (5) @(negedge mclk_i);
        nrst_i = 1'b1;
        check(static_op_o, 1'b1);
        for (int m = 0; m < 4; m++) begin
            host_cmd_model_i.send(`CMD_MODE, m);
            query(`QRY_MODE, m);
        end
        for (int k = 0; k < 4; k++)
            for (int v = 0; v < 2; v++) begin
                host_cmd_model_i.send(sc[k], v);
                query(qc[k], (k == 3) ? 1 - v : v);
            end
        for (int s = 0; s < 3; s++) begin
            host_cmd_model_i.send(`CMD_SENSE, s);
            query(`QRY_SENSE, s == 1);
            check(sense_auto_o, s == 2);
        end
        for (int b = 1; b >= 0; b--) begin
            host_cmd_model_i.send(`CMD_RANGE, b);
            check(second_range_o, b);
            host_cmd_model_i.send(`CMD_METER_SIGN_SELECT, b);
            check(meter_sign_neg_o, b);
        end
        $display("state queries done");
        meas(24'd15, 24'd150, 24'd150, 1'b1);
        host_cmd_model_i.set_band(`LIM_LOWER_CURR, 24'd10, 24'd20);
        host_cmd_model_i.set_band(`LIM_LOWER_PWR, 24'd100, 24'd200);
        host_cmd_model_i.set_band(`LIM_LOWER_VOLT, 24'd100, 24'd200);
        host_cmd_model_i.set_band(`LIM_SHORT_LOWER, 24'd10, 24'd20);
        query({3'h1, `LIM_UPPER_VOLT}, 24'd200);
        query({3'h1, `LIM_LOWER_CURR}, 24'd10);
        meas(24'd20, 24'd150, 24'd150, 1'b0);
        meas(24'd10, 24'd150, 24'd150, 1'b0);
        meas(24'd9, 24'd150, 24'd150, 1'b1);
        meas(24'd21, 24'd150, 24'd150, 1'b1);
        meas(24'd15, 24'd99, 24'd150, 1'b1);
        meas(24'd15, 24'd201, 24'd150, 1'b1);
        meas(24'd15, 24'd150, 24'd201, 1'b1);
        query(`QRY_NG, 24'h1);
        meas(24'd15, 24'd150, 24'd15, 1'b1);
        $display("band checks done");
        for (int f = 0; f < 5; f++) begin
            host_cmd_model_i.send(`CMD_TFUNC, f);
            query(`QRY_TFUNC, f);
        end
        host_cmd_model_i.send(`CMD_START, 24'h0);
        check({test_running_o, short_test_active_o}, 2'h3);
        query(`QRY_SHORT, 24'h0);
        check(out_of_band_flag_o, 1'b0);
        host_cmd_model_i.send(`CMD_TFUNC, `TF_OVER_CURR);
        query(`QRY_TFUNC, `TF_SHORT);
        host_cmd_model_i.send(`CMD_STOP, 24'h0);
        query(`QRY_SHORT, 24'h1);
        check({test_running_o, out_of_band_flag_o}, 2'h1);
        host_cmd_model_i.send(`CMD_STOP, 24'h0);
        check({test_running_o, short_test_active_o}, 2'h0);
        host_cmd_model_i.send(`CMD_TFUNC, `TF_NORMAL);
        host_cmd_model_i.send(`CMD_START, 24'h0);
        check({test_running_o, short_test_active_o}, 2'h2);
        host_cmd_model_i.send(`CMD_STOP, 24'h0);
        host_cmd_model_i.send(`CMD_SHORT, 24'h1);
        query(`QRY_SHORT, 24'h0);
        check(out_of_band_flag_o, 1'b0);
        host_cmd_model_i.send(`CMD_SHORT, 24'h0);
        $display("test control done");
        host_cmd_model_i.send(`CMD_LOAD, 24'h0);
        host_cmd_model_i.send(`CMD_START, 24'h0);
        check({test_running_o, error_status_o[4]}, 2'h1);
        host_cmd_model_i.send(`CMD_TFUNC, 24'h5);
        check({error_status_o[5], test_function_select_o}, 4'h8);
        host_cmd_model_i.send(6'h3f, 24'h0);
        @(negedge mclk_i);
        ch1_err_i = 4'h5;
        @(negedge mclk_i);
        ch1_err_i = 4'h0;
        for (int t = 0; t < 4; t++) begin
            {over_current_trip_i, over_voltage_trip_i, over_temp_trip_i, over_power_trip_i} = 4'h1 << t;
            @(negedge mclk_i);
            {over_current_trip_i, over_voltage_trip_i, over_temp_trip_i, over_power_trip_i} = 4'h0;
            @(negedge mclk_i);
            check(protection_status_o, (4'h2 << t) - 4'h1);
        end
        query(`QRY_ERR, 24'h35);
        query(`QRY_PROTECTION_STATUS, 24'hf);
        host_cmd_model_i.send(`CMD_CLR, 24'h0);
        check({error_status_o, protection_status_o}, 10'h0);
        query(`QRY_ERR, 24'h0);
        $display("status registers done");
        final_report();
    end
endmodule // load_limit_status_commands_tb
`default_nettype wire
